// file: design/tmab_top.sv
// Behaviour
// - Timer mode read: live count, ones at reload.
// - Event read at reload: ones down, zeros up.
// - Halted write reads back before start.
// - One-shot stop: reload, output low, interrupt only if counting.
// - One-shot output synchronised to count source.
// - Entering one-shot from timer or event interrupts.
// - Retrigger: one more down count, then reload.
// - Entering PWM from timer or event interrupts.
// - PWM stop while high: low, interrupt.
// - PWM stop while low: no change.
// - Timer B timer or event read: live count, ones at reload.
// - Timer B halted write reads back unchanged.
// - Measurement select change while counting interrupts.
`timescale 1ns/100ps

// ************************************************************
// Three-stage pin synchroniser with agreement filter.
// ************************************************************
module tmab_sync (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PIN,
  output logic LEVEL
);
  logic s1;
  logic s2;
  logic s3;

  // Shift the pin through three flip-flops.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= PIN;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a new level only when the last two stages agree.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      LEVEL <= 1'b0;
    else if (s2 == s3)
      LEVEL <= s3;
  end
endmodule : tmab_sync

// ************************************************************
// Timer A and timer B with an APB register slave.
// ************************************************************
module tmab_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_A_TRIGGER_INPUT,
  input wire logic TIMER_B_EVENT_INPUT,
  output logic TIMER_A_OUTPUT_PIN
);
  import tmab_pkg::*;

  logic a_lvl;
  logic a_lvl_d;
  logic a_edge;
  logic b_lvl;
  logic b_lvl_d;
  logic b_edge;
  logic [7:0] presc;
  logic src_tick;
  logic apb_wr;
  logic apb_setup;
  logic hit;
  logic ta_run;
  tmab_amode_t ta_mode;
  logic ta_rld_en;
  logic ta_up;
  logic ta_ext;
  logic [15:0] ta_cnt;
  logic [15:0] ta_rld;
  logic ta_irq;
  logic ta_out;
  logic ta_armed;
  logic [1:0] ta_rt;
  logic ta_pend;
  logic ta_tick;
  logic ta_term;
  logic ta_rel;
  logic ta_trig;
  logic ta_stop;
  logic ta_os_end;
  logic ta_set;
  logic [15:0] ta_dec;
  logic tb_run;
  tmab_bmode_t tb_mode;
  logic tb_msel;
  logic [15:0] tb_cnt;
  logic [15:0] tb_rld;
  logic tb_irq;
  logic tb_tick;
  logic tb_rel;
  logic tb_medge;
  logic tb_set;
  tmab_amode_t next_ta_mode;

  // ************************************************************
  // Input synchronisers and edge detection.
  // ************************************************************
  tmab_sync u_sync_a (
    .CLK(CLK),
    .RST(RST),
    .PIN(TIMER_A_TRIGGER_INPUT),
    .LEVEL(a_lvl)
  );

  tmab_sync u_sync_b (
    .CLK(CLK),
    .RST(RST),
    .PIN(TIMER_B_EVENT_INPUT),
    .LEVEL(b_lvl)
  );

  // Delay the filtered levels for edge detection.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      a_lvl_d <= 1'b0;
      b_lvl_d <= 1'b0;
    end
    else
    begin
      a_lvl_d <= a_lvl;
      b_lvl_d <= b_lvl;
    end
  end

  assign a_edge = a_lvl & ~a_lvl_d;
  assign b_edge = b_lvl & ~b_lvl_d;

  // ************************************************************
  // Internal count source.
  // ************************************************************
  // Divide the clock down to the count-source tick.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      presc <= 8'h00;
    else if (src_tick)
      presc <= 8'h00;
    else
      presc <= presc + 8'h01;
  end

  assign src_tick = (presc == SRC_DIV - 8'h01);

  // ************************************************************
  // APB decode.
  // ************************************************************
  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign apb_setup = PSEL & ~PENABLE;
  assign hit = (PADDR == TA_CTRL_OFS) | (PADDR == TA_COUNT_OFS) | (PADDR == TA_STAT_OFS) |
               (PADDR == TB_CTRL_OFS) | (PADDR == TB_COUNT_OFS) | (PADDR == TB_STAT_OFS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;

  // ************************************************************
  // Timer A control and derived events.
  // ************************************************************
  assign next_ta_mode = tmab_amode_t'(PWDATA[CTRL_MODE_MSB:CTRL_MODE_LSB]);
  assign ta_stop = apb_wr & (PADDR == TA_CTRL_OFS) & ta_run & ~PWDATA[CTRL_START_BIT];
  assign ta_tick = (ta_mode == TA_EVENT) ? a_edge : src_tick;
  assign ta_term = (ta_mode == TA_EVENT && ta_up) ? (ta_cnt == CNT_ONES) : (ta_cnt == CNT_ZEROS);
  assign ta_rel = ta_run & ta_tick & ta_term & ((ta_mode == TA_TIMER) | (ta_mode == TA_EVENT));
  assign ta_trig = ta_run & (ta_mode == TA_ONESHOT) &
                   (ta_ext ? a_edge : (apb_wr & (PADDR == TA_CTRL_OFS) & PWDATA[CTRL_SWTRIG_BIT]));
  assign ta_os_end = ta_run & (ta_mode == TA_ONESHOT) & ta_armed & src_tick &
                     (ta_cnt == CNT_ZEROS) & (ta_rt != 2'd2);
  assign ta_dec = ta_cnt - 16'h0001;

  // Control register of timer A.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ta_run <= 1'b0;
      ta_mode <= TA_TIMER;
      ta_rld_en <= 1'b1;
      ta_up <= 1'b0;
      ta_ext <= 1'b0;
    end
    else if (apb_wr && PADDR == TA_CTRL_OFS)
    begin
      ta_run <= PWDATA[CTRL_START_BIT];
      ta_mode <= next_ta_mode;
      ta_rld_en <= PWDATA[CTRL_RELOAD_BIT];
      ta_up <= PWDATA[CTRL_UP_BIT];
      ta_ext <= PWDATA[CTRL_EXT_BIT];
    end
  end

  // Reload register of timer A; a write while halted also loads the counter.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ta_rld <= CNT_RESET;
    else if (apb_wr && PADDR == TA_COUNT_OFS)
      ta_rld <= PWDATA[15:0];
  end

  // Trigger waits for the next count-source tick before it acts.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ta_pend <= 1'b0;
    else if (ta_stop || !ta_run)
      ta_pend <= 1'b0;
    else if (ta_trig)
      ta_pend <= 1'b1;
    else if (src_tick)
      ta_pend <= 1'b0;
  end

  // ************************************************************
  // Timer A counter, output and one-shot sequencing.
  // ************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ta_cnt <= CNT_RESET;
      ta_out <= 1'b0;
      ta_armed <= 1'b0;
      ta_rt <= 2'd0;
    end
    else if (apb_wr && PADDR == TA_COUNT_OFS && !ta_run)
      ta_cnt <= PWDATA[15:0];
    else if (ta_stop)
    begin
      if (ta_mode == TA_ONESHOT)
      begin
        ta_cnt <= ta_rld;
        ta_armed <= 1'b0;
        ta_rt <= 2'd0;
      end
      ta_out <= 1'b0;
    end
    else if (ta_run)
    begin
      case (ta_mode)
        TA_TIMER:
        begin
          if (ta_tick)
            ta_cnt <= ta_term ? ta_rld : ta_dec;
        end
        TA_EVENT:
        begin
          // Free-run type wraps through all ones or all zeros.
          if (ta_tick)
            ta_cnt <= (ta_term && ta_rld_en) ? ta_rld : (ta_up ? ta_cnt + 16'h0001 : ta_dec);
        end
        TA_ONESHOT:
        begin
          if (ta_trig && ta_armed)
            ta_rt <= 2'd1;
          if (src_tick)
          begin
            if (!ta_armed && ta_pend)
            begin
              ta_armed <= 1'b1;
              ta_out <= 1'b1;
              ta_cnt <= ta_rld;
            end
            else if (ta_armed && ta_rt == 2'd2)
            begin
              ta_cnt <= ta_rld;
              ta_rt <= 2'd0;
            end
            else if (ta_os_end)
            begin
              ta_armed <= 1'b0;
              ta_out <= 1'b0;
              ta_cnt <= ta_rld;
            end
            else if (ta_armed)
            begin
              ta_cnt <= ta_dec;
              if (ta_rt == 2'd1)
                ta_rt <= 2'd2;
            end
          end
        end
        TA_PWM:
        begin
          // Output is high while the descending count sits below the reload value.
          if (src_tick)
          begin
            ta_cnt <= ta_dec;
            ta_out <= (ta_dec < ta_rld);
          end
        end
        default:
        begin
          ta_cnt <= ta_cnt;
        end
      endcase
    end
  end

  assign TIMER_A_OUTPUT_PIN = ta_out;

  // ************************************************************
  // Timer A interrupt request; a new event beats the clear.
  // ************************************************************
  assign ta_set = ta_rel | ta_os_end |
    (ta_stop & (ta_mode == TA_ONESHOT) & ta_armed) |
    (ta_stop & (ta_mode == TA_PWM) & ta_out) |
    (ta_run & (ta_mode == TA_PWM) & src_tick & (ta_cnt == CNT_ZEROS)) |
    (apb_wr & (PADDR == TA_CTRL_OFS) & ((ta_mode == TA_TIMER) | (ta_mode == TA_EVENT)) &
     ((next_ta_mode == TA_ONESHOT) | (next_ta_mode == TA_PWM)));

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ta_irq <= 1'b0;
    else if (ta_set)
      ta_irq <= 1'b1;
    else if (apb_wr && PADDR == TA_STAT_OFS && PWDATA[STAT_IRQ_BIT])
      ta_irq <= 1'b0;
  end

  // ************************************************************
  // Timer B control, counter and measurement.
  // ************************************************************
  assign tb_tick = (tb_mode == TB_EVENT) ? b_edge : src_tick;
  assign tb_rel = tb_run & tb_tick & (tb_cnt == CNT_ZEROS) &
                  ((tb_mode == TB_TIMER) | (tb_mode == TB_EVENT));
  assign tb_medge = tb_msel ? (b_lvl != b_lvl_d) : b_edge;

  // Control register of timer B.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tb_run <= 1'b0;
      tb_mode <= TB_TIMER;
      tb_msel <= 1'b0;
    end
    else if (apb_wr && PADDR == TB_CTRL_OFS)
    begin
      tb_run <= PWDATA[CTRL_START_BIT];
      tb_mode <= tmab_bmode_t'(PWDATA[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      tb_msel <= PWDATA[CTRL_MSEL_BIT];
    end
  end

  // Counter and reload register of timer B.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tb_cnt <= CNT_RESET;
      tb_rld <= CNT_RESET;
    end
    else if (apb_wr && PADDR == TB_COUNT_OFS)
    begin
      tb_rld <= PWDATA[15:0];
      if (!tb_run)
        tb_cnt <= PWDATA[15:0];
    end
    else if (tb_run)
    begin
      case (tb_mode)
        TB_TIMER, TB_EVENT:
        begin
          if (tb_tick)
            tb_cnt <= (tb_cnt == CNT_ZEROS) ? tb_rld : tb_cnt - 16'h0001;
        end
        TB_MEASURE:
        begin
          // Capture the elapsed count on each measured edge and restart.
          if (tb_medge)
          begin
            tb_rld <= tb_cnt;
            tb_cnt <= CNT_ZEROS;
          end
          else if (src_tick)
            tb_cnt <= tb_cnt + 16'h0001;
        end
        default:
        begin
          tb_cnt <= tb_cnt;
        end
      endcase
    end
  end

  // Timer B interrupt request; a new event beats the clear.
  assign tb_set = tb_rel | (tb_run & (tb_mode == TB_MEASURE) & tb_medge) |
    (apb_wr & (PADDR == TB_CTRL_OFS) & tb_run & (tb_mode == TB_MEASURE) &
     (PWDATA[CTRL_MSEL_BIT] != tb_msel));

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tb_irq <= 1'b0;
    else if (tb_set)
      tb_irq <= 1'b1;
    else if (apb_wr && PADDR == TB_STAT_OFS && PWDATA[STAT_IRQ_BIT])
      tb_irq <= 1'b0;
  end

  // ************************************************************
  // Read data, captured in the setup cycle.
  // ************************************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      PRDATA <= RD_ZERO;
    else if (apb_setup && !PWRITE)
    begin
      case (PADDR)
        TA_CTRL_OFS:
          PRDATA <= {26'h0, ta_ext, ta_up, ta_rld_en, ta_mode, ta_run};
        TA_COUNT_OFS:
          PRDATA <= {16'h0, ta_rel ? ((ta_mode == TA_EVENT && ta_up) ? CNT_ZEROS : CNT_ONES)
                                   : ta_cnt};
        TA_STAT_OFS:
          PRDATA <= {30'h0, ta_out, ta_irq};
        TB_CTRL_OFS:
          PRDATA <= {28'h0, tb_msel, tb_mode, tb_run};
        TB_COUNT_OFS:
          PRDATA <= {16'h0, tb_rel ? CNT_ONES : (tb_mode == TB_MEASURE ? tb_rld : tb_cnt)};
        TB_STAT_OFS:
          PRDATA <= {31'h0, tb_irq};
        default:
          PRDATA <= RD_ZERO;
      endcase
    end
  end
endmodule : tmab_top

// file: design/tmab_pkg.sv
package tmab_pkg;

  // ************************************************************
  // Register offsets (byte addresses on the APB bus).
  // ************************************************************
  localparam logic [7:0] TA_CTRL_OFS = 8'h00;
  localparam logic [7:0] TA_COUNT_OFS = 8'h04;
  localparam logic [7:0] TA_STAT_OFS = 8'h08;
  localparam logic [7:0] TB_CTRL_OFS = 8'h0c;
  localparam logic [7:0] TB_COUNT_OFS = 8'h10;
  localparam logic [7:0] TB_STAT_OFS = 8'h14;

  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;
  localparam int CTRL_RELOAD_BIT = 3;
  localparam int CTRL_MSEL_BIT = 3;
  localparam int CTRL_UP_BIT = 4;
  localparam int CTRL_EXT_BIT = 5;
  localparam int CTRL_SWTRIG_BIT = 6;
  localparam int STAT_IRQ_BIT = 0;
  localparam int STAT_OUT_BIT = 1;

  // ************************************************************
  // Reset values and count constants.
  // ************************************************************
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONES = 16'hffff;
  localparam logic [15:0] CNT_ZEROS = 16'h0000;
  localparam logic [7:0] SRC_DIV = 8'h04;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  // ************************************************************
  // Timing: trigger guard before the one-shot count reaches zero.
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRIG_GUARD_NS = 300;
  localparam int TRIG_GUARD_CYC = (TRIG_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Operating modes.
  // ************************************************************
  typedef enum logic [1:0] {TA_TIMER, TA_EVENT, TA_ONESHOT, TA_PWM} tmab_amode_t;
  typedef enum logic [1:0] {TB_TIMER, TB_EVENT, TB_MEASURE, TB_SPARE} tmab_bmode_t;

endpackage : tmab_pkg

// file: bench/tmab_assertions.sv
`timescale 1ns/100ps

// ********
// Port checker for the timer pair.
// ********
module tmab_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_A_TRIGGER_INPUT,
  input wire logic TIMER_B_EVENT_INPUT,
  input wire logic TIMER_A_OUTPUT_PIN
);
  import tmab_pkg::*;
  logic setup_rd;
  logic mapped;
  logic ta_wr;
  logic [5:0] ctrl;
  logic [2:0] idle;

  // Decode of the access in flight.
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= TB_STAT_OFS);
  assign ta_wr = PSEL && PENABLE && PWRITE && (PADDR == TA_CTRL_OFS);

  // Shadow of the timer A control word and cycles since it stopped.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl <= 6'h00;
      idle <= 3'h4;
    end
    else
    begin
      if (ta_wr)
        ctrl <= PWDATA[5:0];
      if (ctrl[0] || ta_wr)
        idle <= 3'h0;
      else if (idle != 3'h7)
        idle <= idle + 3'h1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  pready_high_a: assert property (PREADY)
    else $error("ready low");
  err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  err_unmapped_a: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  rdata_hold_a: assert property (!setup_rd |=> $stable(PRDATA))
    else $error("read data moved");
  unmapped_zero_a: assert property (setup_rd && !mapped |=> PRDATA == RD_ZERO)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (setup_rd |=> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  stop_low_a: assert property (ta_wr && !PWDATA[0] && ctrl[0] && ctrl[2]
    |-> ##[1:3] !TIMER_A_OUTPUT_PIN) else $error("output high after stop");
  stopped_low_a: assert property (idle == 3'h7 && ctrl[2] |-> !TIMER_A_OUTPUT_PIN)
    else $error("output high while stopped");
  trig_out_a: assert property (ctrl[2:0] == 3'h5 && ctrl[5] && $rose(TIMER_A_TRIGGER_INPUT)
    |-> ##[1:14] TIMER_A_OUTPUT_PIN) else $error("trigger gave no output");

  pwm_start_c: cover property (ta_wr && PWDATA[2:0] == 3'h7);
  out_rise_c: cover property ($rose(TIMER_A_OUTPUT_PIN));
  refused_c: cover property (PSLVERR);
endmodule : tmab_assertions

bind tmab_top tmab_assertions chk_u (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_A_TRIGGER_INPUT(TIMER_A_TRIGGER_INPUT), .TIMER_B_EVENT_INPUT(TIMER_B_EVENT_INPUT),
  .TIMER_A_OUTPUT_PIN(TIMER_A_OUTPUT_PIN)
);

// file: bench/tmab_pin_model.sv
`timescale 1ns/100ps

// ********
// External trigger and event source.
// ********
module tmab_pin_model (
  input wire logic clk,
  output logic trig,
  output logic evt
);
  import tmab_pkg::*;

  // Both pins rest low.
  initial
  begin
    trig = 1'b0;
    evt = 1'b0;
  end

  // One pulse, long enough to pass the input filter.
  // Callers give one pulse per one-shot count, so none lands near zero.
  task automatic pulse(input logic on_trig);
    repeat (SRC_DIV + 8'h01) @(posedge clk);
    if (on_trig)
      trig <= 1'b1;
    else
      evt <= 1'b1;
    repeat (SRC_DIV + 8'h02) @(posedge clk);
    trig <= 1'b0;
    evt <= 1'b0;
  endtask : pulse
endmodule : tmab_pin_model

// file: bench/testbench.sv
`timescale 1ns/100ps

// ********
// Self-checking bench for the timer pair.
// ********
module testbench;
  import tmab_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig;
  logic evt;
  logic pin_out;
  logic [31:0] rd;
  logic err;
  logic [7:0] cnt_ofs [2] = '{TA_COUNT_OFS, TB_COUNT_OFS};
  logic [7:0] ctl_ofs [2] = '{TA_CTRL_OFS, TB_CTRL_OFS};
  int hits;
  int n_mismatch = 0;
  int compares = 0;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  tmab_top dut_u (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_A_TRIGGER_INPUT(trig), .TIMER_B_EVENT_INPUT(evt), .TIMER_A_OUTPUT_PIN(pin_out)
  );

  tmab_pin_model pin_u (.clk(clk), .trig(trig), .evt(evt));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task give_verdict;
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // One bus transfer; the request holds until ready is seen.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    check(name, rd, exp);
  endtask : rd_chk

  task wait_pin(input logic v, input int lim);
    for (int k = 0; k < lim && pin_out !== v; k++)
      @(posedge clk);
    check("pin", {31'h0, pin_out}, {31'h0, v});
  endtask : wait_pin

  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk("ta_count_rst", TA_COUNT_OFS, 32'h0);
    rd_chk("ta_stat_rst", TA_STAT_OFS, 32'h0);
    rd_chk("unmapped", 8'h18, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      xfer(1'b1, cnt_ofs[i], 32'h1234 + i);
      rd_chk("halt_rd", cnt_ofs[i], 32'h1234 + i);
    end
    // Reads every three cycles walk across the reload tick.
    for (int i = 0; i < 2; i++)
    begin
      hits = 0;
      xfer(1'b1, cnt_ofs[i], 32'h1);
      xfer(1'b1, ctl_ofs[i], 32'h1);
      repeat (24)
      begin
        xfer(1'b0, cnt_ofs[i], 32'h0);
        hits += int'(rd === 32'hffff);
        check("live", {31'h0, rd === 32'h0 || rd === 32'h1 || rd === 32'hffff}, 32'h1);
      end
      check("reload_ones", {31'h0, hits > 0}, 32'h1);
      xfer(1'b1, ctl_ofs[i], 32'h0);
    end
    // One-shot entry, software trigger, then stop mid-count.
    xfer(1'b1, TA_COUNT_OFS, 32'h64);
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    rd_chk("os_pre_clr", TA_STAT_OFS, 32'h0);
    xfer(1'b1, TA_CTRL_OFS, 32'h5);
    rd_chk("os_mode_irq", TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_CTRL_OFS, 32'h45);
    wait_pin(1'b1, 20);
    xfer(1'b1, TA_CTRL_OFS, 32'h4);
    rd_chk("os_stop", TA_STAT_OFS, 32'h1);
    rd_chk("os_reload", TA_COUNT_OFS, 32'h64);
    // External trigger runs a short count to zero.
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_COUNT_OFS, 32'h3);
    xfer(1'b1, TA_CTRL_OFS, 32'h25);
    pin_u.pulse(1'b1);
    wait_pin(1'b1, 20);
    wait_pin(1'b0, 40);
    rd_chk("os_done", TA_STAT_OFS, 32'h1);
    // Timer to PWM, stop while high, then stop while low.
    xfer(1'b1, TA_CTRL_OFS, 32'h0);
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_COUNT_OFS, 32'h1000);
    xfer(1'b1, TA_CTRL_OFS, 32'h7);
    wait_pin(1'b1, 20);
    rd_chk("pwm_mode_irq", TA_STAT_OFS, 32'h3);
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_CTRL_OFS, 32'h6);
    rd_chk("pwm_stop_hi", TA_STAT_OFS, 32'h1);
    xfer(1'b1, TA_CTRL_OFS, 32'h7);
    xfer(1'b1, TA_COUNT_OFS, 32'h0);
    repeat (8) @(posedge clk);
    xfer(1'b1, TA_STAT_OFS, 32'h1);
    rd_chk("pwm_low", TA_STAT_OFS, 32'h0);
    xfer(1'b1, TA_CTRL_OFS, 32'h6);
    rd_chk("pwm_stop_lo", TA_STAT_OFS, 32'h0);
    // Timer A event counter: reload-type overflow and underflow, then free-run and rewrite.
    xfer(1'b1, TA_COUNT_OFS, 32'hffff);
    xfer(1'b1, TA_CTRL_OFS, 32'h1b);
    xfer(1'b1, TA_COUNT_OFS, 32'h0);
    // The read setup edge lands on the cycle in which the filtered edge counts.
    fork
      pin_u.pulse(1'b1);
      begin
        repeat (9) @(posedge clk);
        rd_chk("ev_up_ovf", TA_COUNT_OFS, 32'h0);
      end
    join
    // Direction change: restart down in reload type, free-run after one pulse.
    xfer(1'b1, TA_CTRL_OFS, 32'h1a);
    xfer(1'b1, TA_COUNT_OFS, 32'h0);
    xfer(1'b1, TA_CTRL_OFS, 32'hb);
    fork
      pin_u.pulse(1'b1);
      begin
        repeat (9) @(posedge clk);
        rd_chk("ev_dn_unf", TA_COUNT_OFS, 32'hffff);
      end
    join
    xfer(1'b1, TA_CTRL_OFS, 32'h3);
    pin_u.pulse(1'b1);
    rd_chk("ev_freerun", TA_COUNT_OFS, 32'hffff);
    // A stopped free-run counter is written again before any restart.
    xfer(1'b1, TA_CTRL_OFS, 32'h2);
    xfer(1'b1, TA_COUNT_OFS, 32'h5);
    rd_chk("ev_rewrite", TA_COUNT_OFS, 32'h5);
    // Timer B counts events, then a select change while measuring.
    xfer(1'b1, TB_COUNT_OFS, 32'ha);
    xfer(1'b1, TB_CTRL_OFS, 32'h3);
    repeat (3) pin_u.pulse(1'b0);
    repeat (8) @(posedge clk);
    rd_chk("tb_events", TB_COUNT_OFS, 32'h7);
    xfer(1'b1, TB_CTRL_OFS, 32'h0);
    xfer(1'b1, TB_CTRL_OFS, 32'h5);
    xfer(1'b1, TB_STAT_OFS, 32'h1);
    rd_chk("tb_clear", TB_STAT_OFS, 32'h0);
    xfer(1'b1, TB_CTRL_OFS, 32'hd);
    rd_chk("tb_msel_irq", TB_STAT_OFS, 32'h1);
    give_verdict();
  end

  // Watchdog well past the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
